// *** rtl/eitfpc_pkg.sv ***
// Purpose: shared constants and types of the interrupt-source, timer flag and power control block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: register indices are scaled by four to form byte addresses
package eitfpc_pkg;
  // bus geometry
  localparam int EITFPC_ADDR_W = 12;
  localparam int EITFPC_IDX_W = 10;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_PIN_EN = 10'h084;
  localparam logic [9:0] IDX_PIN_FLAG = 10'h085;
  localparam logic [9:0] IDX_PWM_FLAG = 10'h086;
  localparam logic [9:0] IDX_PWR = 10'h087;
  localparam logic [9:0] IDX_TCTL = 10'h088;
  localparam logic [9:0] IDX_CTRL = 10'h090;
  localparam logic [9:0] IDX_STAT = 10'h091;
  localparam logic [9:0] IDX_MASK = 10'h092;
  // power_and_baud_control bit positions
  localparam int PWR_BAUD = 7;
  localparam int PWR_FLAG1 = 3;
  localparam int PWR_FLAG0 = 2;
  localparam int PWR_STOP = 1;
  localparam int PWR_IDLE = 0;
  // timer_and_ext_int_control bit positions
  localparam int TC_OVF1 = 7;
  localparam int TC_RUN1 = 6;
  localparam int TC_OVF0 = 5;
  localparam int TC_RUN0 = 4;
  localparam int TC_EDGE1 = 3;
  localparam int TC_TRIG1 = 2;
  localparam int TC_EDGE0 = 1;
  localparam int TC_TRIG0 = 0;
  // control register bit positions
  localparam int CTRL_SHARED = 0;
  localparam int CTRL_GIE = 1;
  // event status bit positions
  localparam int EV_PIN = 0;
  localparam int EV_PWM = 1;
  localparam int EV_TMR = 2;
  localparam int EV_EXT = 3;
  localparam int EV_WAKE = 4;
  localparam int EITFPC_NEV = 5;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] SYNC_IDLE = 10'h3FF;
  // power mode
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_STOP} eitfpc_pmode_e;
  // vector acknowledges from the cpu core, one-cycle pulses
  typedef struct packed {
    logic tmr1;
    logic ext1;
    logic tmr0;
    logic ext0;
  } eitfpc_ack_s;
  // state of the pin synchroniser: two sync stages and an edge history
  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
    logic [9:0] s3;
  } eitfpc_sync_s;
  // whole state of the controller
  typedef struct packed {
    logic [7:0] pin_en;
    logic [7:0] pin_flag;
    logic [2:0] pwm_flag;
    logic [7:0] pwr;
    logic [7:0] tctl;
    logic [1:0] ctrl;
    logic [EITFPC_NEV-1:0] stat;
    logic [EITFPC_NEV-1:0] mask;
    logic [31:0] prdata;
    logic wake;
    eitfpc_pmode_e pmode;
  } eitfpc_state_s;
endpackage

// *** rtl/eitfpc_pin_sync.sv ***
// Purpose: two-stage synchroniser and falling edge detector for ten interrupt pins
// Assumes: pins are asynchronous to MCLK and idle high
// Notes: the edge history looks only at the second stage
`timescale 1ns/10ps
`default_nettype none
module eitfpc_pin_sync (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [9:0] PIN_ASYNC,
  output logic [9:0] PIN_LEVEL,
  output logic [9:0] PIN_FALL
);
  import eitfpc_pkg::*;

  eitfpc_sync_s st_reg; // registered state
  eitfpc_sync_s st_next; // next state

  // shift the pins through the stages; reset to idle high so no false edge
  always_comb begin
    st_next = st_reg;
    st_next.s1 = PIN_ASYNC;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  // single registered state
  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_reg <= '{s1: SYNC_IDLE, s2: SYNC_IDLE, s3: SYNC_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign PIN_LEVEL = st_reg.s2; // synchronised level
  assign PIN_FALL = st_reg.s3 & ~st_reg.s2; // one-cycle pulse per falling edge
endmodule // eitfpc_pin_sync
`default_nettype wire

// *** rtl/eitfpc_ctrl.sv ***
// Purpose: interrupt-source control, flags, timer run bits and power mode entry
// Assumes: apb slave, zero wait states; timer counters and uart live elsewhere
// Notes: all pins pass the synchroniser before any logic reads them
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - pin enable bits gate interrupt and wake
// - enabled pin wakes stop regardless global enable
// - shared enable also needed for pin events
// - pin flags set by hardware, write zero clears
// - three pwm flags, write zero clears
// - power bit seven doubles uart one baud
// - power bits three, two are plain flags
// - writing power bit one enters stop
// - writing power bit zero enters idle
// - timer one overflow flag, cleared on vector
// - timer zero overflow flag, cleared on vector
// - run bits start and stop timers
// - ext one falling edge sets flag
// - ext zero falling edge sets flag
// - control bit two selects ext one trigger
// - control bit zero selects ext zero trigger
module eitfpc_ctrl (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [eitfpc_pkg::EITFPC_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] EXT_PIN,
  input wire logic EXT_ZERO_PIN,
  input wire logic EXT_ONE_PIN,
  input wire logic [2:0] PWM_EVT,
  input wire logic TMR0_OVF,
  input wire logic TMR1_OVF,
  input wire eitfpc_pkg::eitfpc_ack_s VEC_ACK,
  output logic EXT_PIN_IRQ,
  output logic EXT_ZERO_REQ,
  output logic EXT_ONE_REQ,
  output logic TMR0_IRQ,
  output logic TMR1_IRQ,
  output logic PWM_IRQ,
  output logic [1:0] TIMER_RUN,
  output logic BAUD_DOUBLE,
  output logic IDLE_MODE,
  output logic STOP_MODE,
  output logic WAKE,
  output logic IRQ
);
  import eitfpc_pkg::*;

  // decode: is this index one of ours
  function automatic logic reg_hit(input logic [9:0] idx);
    unique case (idx)
      IDX_PIN_EN, IDX_PIN_FLAG, IDX_PWM_FLAG, IDX_PWR, IDX_TCTL: reg_hit = 1'b1;
      IDX_CTRL, IDX_STAT, IDX_MASK: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // read mux; upper bits read as zero
  function automatic logic [31:0] rd_word(input logic [9:0] idx, input eitfpc_state_s s);
    logic [7:0] b;
    b = RST_BYTE;
    unique case (idx)
      IDX_PIN_EN: b = s.pin_en;
      IDX_PIN_FLAG: b = s.pin_flag;
      IDX_PWM_FLAG: b = {5'h00, s.pwm_flag};
      IDX_PWR: b = s.pwr;
      IDX_TCTL: b = s.tctl;
      IDX_CTRL: b = {6'h00, s.ctrl};
      IDX_STAT: b = {3'h0, s.stat};
      IDX_MASK: b = {3'h0, s.mask};
      default: b = RST_BYTE;
    endcase
    rd_word = {24'h000000, b};
  endfunction

  eitfpc_state_s st_reg; // all registered state
  eitfpc_state_s st_next; // its next value

  logic [9:0] pin_lvl; // synchronised pin levels, {ext1, ext0, pins 9..2}
  logic [9:0] pin_fall; // falling edge pulses, same order
  logic [9:0] idx; // word index of the access
  logic wr_go; // write takes effect this edge
  logic setup; // setup phase of an apb transfer
  logic shared_en; // shared pin / low-voltage enable
  logic gie; // global interrupt enable
  logic [7:0] pin_set; // pin flags set this cycle
  logic pin_wake; // enabled pin edge while stopped
  logic ext0_set; // ext zero edge flag set
  logic ext1_set; // ext one edge flag set
  logic [EITFPC_NEV-1:0] ev; // events feeding the sticky status
  logic any_req; // any request that ends idle
  logic [7:0] wb; // low byte of write data

  // pins cross into MCLK here before any other logic looks at them
  eitfpc_pin_sync u_sync (
    .MCLK(MCLK),
    .RST(RST),
    .PIN_ASYNC({EXT_ONE_PIN, EXT_ZERO_PIN, EXT_PIN}),
    .PIN_LEVEL(pin_lvl),
    .PIN_FALL(pin_fall)
  );

  // bus decode; zero wait states keeps the cpu path short
  assign idx = PADDR[11:2];
  assign setup = PSEL & ~PENABLE;
  assign wr_go = PSEL & PENABLE & PWRITE & reg_hit(idx);
  assign wb = PWDATA[7:0];
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~reg_hit(idx); // unmapped address
  assign shared_en = st_reg.ctrl[CTRL_SHARED];
  assign gie = st_reg.ctrl[CTRL_GIE];

  // pin events need both their own enable and the shared enable
  assign pin_set = pin_fall[7:0] & st_reg.pin_en & {8{shared_en}};
  // wake ignores the global enable on purpose
  assign pin_wake = (st_reg.pmode == PM_STOP) & (|pin_set);
  // edge flags only in edge mode; level mode uses the pin itself
  assign ext0_set = pin_fall[8] & st_reg.tctl[TC_TRIG0];
  assign ext1_set = pin_fall[9] & st_reg.tctl[TC_TRIG1];

  // event vector for the sticky status register
  assign ev[EV_PIN] = |pin_set;
  assign ev[EV_PWM] = |PWM_EVT;
  assign ev[EV_TMR] = TMR0_OVF | TMR1_OVF;
  assign ev[EV_EXT] = ext0_set | ext1_set;
  assign ev[EV_WAKE] = pin_wake;

  // any pending request leaves idle
  assign any_req = EXT_PIN_IRQ | EXT_ZERO_REQ | EXT_ONE_REQ | TMR0_IRQ | TMR1_IRQ | PWM_IRQ;

  // next state: software writes first, hardware sets on top so sets win
  always_comb begin
    st_next = st_reg;
    st_next.wake = pin_wake;
    // read data captured in setup so prdata comes from a flop
    if (setup) begin
      st_next.prdata = rd_word(idx, st_reg);
    end
    // pin enables
    if (wr_go && idx == IDX_PIN_EN) begin
      st_next.pin_en = wb;
    end
    // pin flags: software writes, hardware sets
    if (wr_go && idx == IDX_PIN_FLAG) begin
      st_next.pin_flag = wb;
    end
    st_next.pin_flag = st_next.pin_flag | pin_set;
    // pwm flags
    if (wr_go && idx == IDX_PWM_FLAG) begin
      st_next.pwm_flag = wb[2:0];
    end
    st_next.pwm_flag = st_next.pwm_flag | PWM_EVT;
    // power and baud control; mode bits follow the mode machine below
    if (wr_go && idx == IDX_PWR) begin
      st_next.pwr[PWR_BAUD] = wb[PWR_BAUD];
      st_next.pwr[PWR_FLAG1] = wb[PWR_FLAG1];
      st_next.pwr[PWR_FLAG0] = wb[PWR_FLAG0];
    end
    // timer and external interrupt control
    if (wr_go && idx == IDX_TCTL) begin
      st_next.tctl = wb;
    end
    // vector acknowledges clear the hardware flags
    if (VEC_ACK.tmr1) begin
      st_next.tctl[TC_OVF1] = 1'b0;
    end
    if (VEC_ACK.tmr0) begin
      st_next.tctl[TC_OVF0] = 1'b0;
    end
    if (VEC_ACK.ext1) begin
      st_next.tctl[TC_EDGE1] = 1'b0;
    end
    if (VEC_ACK.ext0) begin
      st_next.tctl[TC_EDGE0] = 1'b0;
    end
    // a new event in the same cycle as the clear still lands
    if (TMR1_OVF) begin
      st_next.tctl[TC_OVF1] = 1'b1;
    end
    if (TMR0_OVF) begin
      st_next.tctl[TC_OVF0] = 1'b1;
    end
    if (ext1_set) begin
      st_next.tctl[TC_EDGE1] = 1'b1;
    end
    if (ext0_set) begin
      st_next.tctl[TC_EDGE0] = 1'b1;
    end
    // own control and mask registers
    if (wr_go && idx == IDX_CTRL) begin
      st_next.ctrl = wb[1:0];
    end
    if (wr_go && idx == IDX_MASK) begin
      st_next.mask = wb[EITFPC_NEV-1:0];
    end
    // sticky status: write one clears, set wins
    if (wr_go && idx == IDX_STAT) begin
      st_next.stat = st_reg.stat & ~wb[EITFPC_NEV-1:0];
    end
    st_next.stat = st_next.stat | ev;
    // power mode machine
    unique case (st_reg.pmode)
      PM_RUN: begin
        if (wr_go && idx == IDX_PWR && wb[PWR_STOP]) begin
          st_next.pmode = PM_STOP;
        end else if (wr_go && idx == IDX_PWR && wb[PWR_IDLE]) begin
          st_next.pmode = PM_IDLE;
        end
      end
      PM_IDLE: begin
        // any request brings the core back
        if (any_req) begin
          st_next.pmode = PM_RUN;
        end
      end
      PM_STOP: begin
        // only an enabled extra pin can end stop here
        if (pin_wake) begin
          st_next.pmode = PM_RUN;
        end
      end
      default: st_next.pmode = PM_RUN; // the spare code falls back to run
    endcase
    // mode bits read back the current mode
    st_next.pwr[PWR_STOP] = (st_next.pmode == PM_STOP);
    st_next.pwr[PWR_IDLE] = (st_next.pmode == PM_IDLE);
  end

  // single registered state, synchronous reset
  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_reg <= '{pin_en: RST_BYTE, pin_flag: RST_BYTE, pwm_flag: 3'h0, pwr: RST_BYTE,
                  tctl: RST_BYTE, ctrl: 2'h0, stat: '0, mask: '0, prdata: 32'h00000000,
                  wake: 1'b0, pmode: PM_RUN};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign PRDATA = st_reg.prdata;
  // pin request needs own enable, shared enable and the global enable
  assign EXT_PIN_IRQ = gie & shared_en & (|(st_reg.pin_flag & st_reg.pin_en));
  // level mode presents the request as long as the pin is low
  assign EXT_ZERO_REQ = gie & (st_reg.tctl[TC_TRIG0] ? st_reg.tctl[TC_EDGE0] : ~pin_lvl[8]);
  assign EXT_ONE_REQ = gie & (st_reg.tctl[TC_TRIG1] ? st_reg.tctl[TC_EDGE1] : ~pin_lvl[9]);
  assign TMR0_IRQ = gie & st_reg.tctl[TC_OVF0];
  assign TMR1_IRQ = gie & st_reg.tctl[TC_OVF1];
  assign PWM_IRQ = gie & (|st_reg.pwm_flag);
  assign TIMER_RUN = {st_reg.tctl[TC_RUN1], st_reg.tctl[TC_RUN0]};
  assign BAUD_DOUBLE = st_reg.pwr[PWR_BAUD];
  assign IDLE_MODE = st_reg.pwr[PWR_IDLE];
  assign STOP_MODE = st_reg.pwr[PWR_STOP];
  assign WAKE = st_reg.wake;
  assign IRQ = |(st_reg.stat & st_reg.mask);

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // a pin edge that is enabled is captured
  sequence s_pin_event;
    pin_set != 8'h00;
  endsequence

  // a pin edge while stopped
  sequence s_stop_edge;
    STOP_MODE ##0 (|pin_set);
  endsequence

  a_pin_flag_set: assert property (
    s_pin_event |=> ((st_reg.pin_flag & $past(pin_set)) == $past(pin_set)))
    else $error("enabled pin edge did not set its flag");

  a_pin_enable_gate: assert property (
    (st_reg.pin_en == 8'h00) && !(wr_go && idx == IDX_PIN_FLAG) |=> (st_reg.pin_flag & ~$past(st_reg.pin_flag)) == 8'h00)
    else $error("disabled pin set a flag");

  a_shared_gate: assert property (
    !shared_en |-> !EXT_PIN_IRQ && pin_set == 8'h00)
    else $error("pin event passed without shared enable");

  a_stop_wake: assert property (
    s_stop_edge |=> !STOP_MODE && WAKE)
    else $error("enabled pin did not wake from stop");

  a_stop_enter: assert property (
    STOP_MODE == 1'b0 && IDLE_MODE == 1'b0 && wr_go && idx == IDX_PWR && PWDATA[PWR_STOP] |=> STOP_MODE)
    else $error("stop request ignored");

  a_idle_enter: assert property (
    !STOP_MODE && !IDLE_MODE && wr_go && idx == IDX_PWR && !PWDATA[PWR_STOP] && PWDATA[PWR_IDLE]
    |=> IDLE_MODE)
    else $error("idle request ignored");

  a_ovf1_vector: assert property (
    VEC_ACK.tmr1 && !TMR1_OVF |=> !st_reg.tctl[TC_OVF1])
    else $error("timer one flag not cleared on vector");

  a_ovf0_set: assert property (
    TMR0_OVF |=> st_reg.tctl[TC_OVF0])
    else $error("timer zero overflow lost");

  a_ovf0_vector: assert property (
    VEC_ACK.tmr0 && !TMR0_OVF |=> !st_reg.tctl[TC_OVF0])
    else $error("timer zero flag not cleared on vector");

  a_ext1_edge: assert property (
    pin_fall[9] && st_reg.tctl[TC_TRIG1] |=> st_reg.tctl[TC_EDGE1])
    else $error("ext one falling edge lost");

  a_ext0_level: assert property (
    gie && !st_reg.tctl[TC_TRIG0] |-> EXT_ZERO_REQ == !pin_lvl[8])
    else $error("level request does not follow pin");

  a_run_bits: assert property (
    wr_go && idx == IDX_TCTL |=> TIMER_RUN == $past({PWDATA[TC_RUN1], PWDATA[TC_RUN0]}))
    else $error("run bits not taken");

  a_pwm_flag_set: assert property (
    PWM_EVT != 3'h0 |=> (st_reg.pwm_flag & $past(PWM_EVT)) == $past(PWM_EVT))
    else $error("pwm event did not set its flag");

  a_stop_hold: assert property (
    STOP_MODE && pin_set == 8'h00 |=> STOP_MODE)
    else $error("stop left without an enabled pin");

  a_baud_double: assert property (
    wr_go && idx == IDX_PWR |=> BAUD_DOUBLE == $past(PWDATA[PWR_BAUD]))
    else $error("baud doubler not taken");

  a_irq_sticky: assert property (
    s_pin_event ##0 st_reg.mask[EV_PIN] |=> IRQ)
    else $error("unmasked event did not raise irq");
endmodule // eitfpc_ctrl
`default_nettype wire

// *** testbench/eitfpc_cpu_model.sv ***
// Purpose: behavioural cpu core that vectors into pending timer and ext requests
// Assumes: requests are levels from the controller, acks are one-cycle pulses
// Notes: a slow core is modelled by a wait before each vector
`timescale 1ns/10ps
`default_nettype none
module eitfpc_cpu_model (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic [3:0] req,
  output eitfpc_pkg::eitfpc_ack_s VEC_ACK
);
  import eitfpc_pkg::*;
  logic [3:0] wait_reg; // cycles waited on the current request
  logic [3:0] ack_reg; // one-hot vector pulse {tmr1,ext1,tmr0,ext0}
  logic [3:0] grant; // lowest set request bit wins, ext zero first
  // fixed priority pick
  always_comb begin
    grant = req & (~req + 4'h1);
  end
  assign VEC_ACK = ack_reg;
  // vector after the wait; pause one cycle so the cleared flag can drop first
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wait_reg <= 4'h0;
      ack_reg <= 4'h0;
    end else begin
      ack_reg <= 4'h0;
      if (!ack_en || req == 4'h0 || ack_reg != 4'h0) begin
        wait_reg <= 4'h0; // idle or just vectored
      end else if (wait_reg >= ack_delay) begin
        ack_reg <= grant;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // eitfpc_cpu_model
`default_nettype wire

// *** testbench/ext_int_timer_flag_power_ctrl_tb.sv ***
// Purpose: self-checking bench of the interrupt-source, flag and power control block
// Assumes: apb master with one idle cycle between transfers
// Notes: pins idle high; a pin event needs three edges to reach the flags
`timescale 1ns/10ps
`default_nettype none
module ext_int_timer_flag_power_ctrl_tb;
  import eitfpc_pkg::*;
  logic MCLK, RST, PSEL, PENABLE, PWRITE; // clock, reset, apb controls
  logic [11:0] PADDR; // byte address
  logic [31:0] PWDATA, PRDATA; // apb data
  logic PREADY, PSLVERR; // apb answer
  logic [9:0] pins; // {one, zero, nine..two}
  logic [2:0] PWM_EVT; // pwm pulses
  logic TMR0_OVF, TMR1_OVF; // overflow pulses
  eitfpc_ack_s VEC_ACK; // from the cpu model
  logic EXT_PIN_IRQ, EXT_ZERO_REQ, EXT_ONE_REQ, TMR0_IRQ, TMR1_IRQ, PWM_IRQ;
  logic [1:0] TIMER_RUN; // run bits
  logic BAUD_DOUBLE, IDLE_MODE, STOP_MODE, WAKE, IRQ; // mode outputs
  logic ack_en; // lets the cpu model vector
  logic [31:0] rdv; // last read data
  logic slverr, woke; // last error response, wake seen
  int err_count, compares, cycles;
  eitfpc_ctrl dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_PIN(pins[7:0]), .EXT_ZERO_PIN(pins[8]), .EXT_ONE_PIN(pins[9]), .PWM_EVT(PWM_EVT),
    .TMR0_OVF(TMR0_OVF), .TMR1_OVF(TMR1_OVF), .VEC_ACK(VEC_ACK), .EXT_PIN_IRQ(EXT_PIN_IRQ),
    .EXT_ZERO_REQ(EXT_ZERO_REQ), .EXT_ONE_REQ(EXT_ONE_REQ), .TMR0_IRQ(TMR0_IRQ), .TMR1_IRQ(TMR1_IRQ),
    .PWM_IRQ(PWM_IRQ), .TIMER_RUN(TIMER_RUN), .BAUD_DOUBLE(BAUD_DOUBLE), .IDLE_MODE(IDLE_MODE),
    .STOP_MODE(STOP_MODE), .WAKE(WAKE), .IRQ(IRQ));
  eitfpc_cpu_model cpu (.MCLK(MCLK), .RST(RST), .ack_en(ack_en), .ack_delay(4'h2),
    .req({TMR1_IRQ, EXT_ONE_REQ, TMR0_IRQ, EXT_ZERO_REQ}), .VEC_ACK(VEC_ACK));
  // 20 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  // counts and verdict, the single place the run ends
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, the sequence needs about 240 cycles
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      give_verdict;
    end
  end
  // compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; starts at the next edge, releases after pready is sampled
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rdv = PRDATA;
    slverr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // let the edge that took the write settle before anyone looks at outputs
    @(negedge MCLK);
  endtask
  task wr(input logic [9:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask
  // low pulse on the pins in mask, long enough for the synchroniser
  task pin_fall(input logic [9:0] mask);
    @(posedge MCLK);
    pins <= ~mask;
    repeat (4) @(posedge MCLK);
    pins <= 10'h3FF;
    repeat (4) @(posedge MCLK);
  endtask
  // main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PWM_EVT, TMR0_OVF, TMR1_OVF, ack_en} = '0;
    pins = 10'h3FF;
    err_count = 0;
    compares = 0;
    cycles = 0;
    RST = 1'b1;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    for (int i = 0; i < 5; i++) rd_chk(IDX_PIN_EN + 10'(i), 32'h0);
    apb(1'b0, 10'h0FF, 32'h0);
    chk({rdv[30:0], slverr}, 32'h1); // unmapped place answers with an error
    wr(IDX_PWR, 32'h8C);
    rd_chk(IDX_PWR, 32'h8C);
    chk(32'(BAUD_DOUBLE), 32'h1);
    wr(IDX_PWR, 32'h0);
    chk(32'(BAUD_DOUBLE), 32'h0);
    wr(IDX_TCTL, 32'h50);
    chk(32'(TIMER_RUN), 32'h3);
    wr(IDX_TCTL, 32'h40);
    chk(32'(TIMER_RUN), 32'h2);
    // pwm flags, clear one by writing zero
    wr(IDX_CTRL, 32'h3);
    @(posedge MCLK) PWM_EVT <= 3'b101;
    @(posedge MCLK) PWM_EVT <= 3'b000;
    rd_chk(IDX_PWM_FLAG, 32'h5);
    chk(32'(PWM_IRQ), 32'h1);
    wr(IDX_PWM_FLAG, 32'h1);
    rd_chk(IDX_PWM_FLAG, 32'h1);
    wr(IDX_PWM_FLAG, 32'h0);
    chk(32'(PWM_IRQ), 32'h0);
    // pin enables and the shared enable
    wr(IDX_PIN_EN, 32'h81);
    wr(IDX_CTRL, 32'h2);
    pin_fall(10'h080);
    rd_chk(IDX_PIN_FLAG, 32'h0);
    wr(IDX_CTRL, 32'h3);
    pin_fall(10'h082);
    rd_chk(IDX_PIN_FLAG, 32'h80);
    chk(32'(EXT_PIN_IRQ), 32'h1);
    wr(IDX_PIN_FLAG, 32'h0);
    rd_chk(IDX_PIN_FLAG, 32'h0);
    // timer overflow flags, cleared on vector
    @(posedge MCLK) {TMR0_OVF, TMR1_OVF} <= 2'b11;
    @(posedge MCLK) {TMR0_OVF, TMR1_OVF} <= 2'b00;
    rd_chk(IDX_TCTL, 32'hE0);
    chk(32'({TMR1_IRQ, TMR0_IRQ}), 32'h3);
    ack_en <= 1'b1;
    repeat (12) @(posedge MCLK);
    rd_chk(IDX_TCTL, 32'h40);
    ack_en <= 1'b0;
    // edge mode on both classic pins
    wr(IDX_TCTL, 32'h05);
    pin_fall(10'h300);
    rd_chk(IDX_TCTL, 32'h0F);
    chk(32'({EXT_ONE_REQ, EXT_ZERO_REQ}), 32'h3);
    ack_en <= 1'b1;
    repeat (12) @(posedge MCLK);
    rd_chk(IDX_TCTL, 32'h05);
    ack_en <= 1'b0;
    // level mode requests while the pin stays low
    wr(IDX_TCTL, 32'h0);
    pins <= 10'h2FF;
    repeat (6) @(posedge MCLK);
    @(negedge MCLK) chk(32'({EXT_ONE_REQ, EXT_ZERO_REQ}), 32'h1);
    rd_chk(IDX_TCTL, 32'h0);
    pins <= 10'h3FF;
    repeat (6) @(posedge MCLK);
    @(negedge MCLK) chk(32'(EXT_ZERO_REQ), 32'h0);
    // stop: a disabled pin keeps it, an enabled one wakes with global enable off
    wr(IDX_CTRL, 32'h1);
    wr(IDX_PWR, 32'h02);
    @(negedge MCLK) chk(32'(STOP_MODE), 32'h1);
    pin_fall(10'h002);
    chk(32'(STOP_MODE), 32'h1);
    woke = 1'b0;
    @(posedge MCLK) pins <= 10'h3FE;
    repeat (10) @(posedge MCLK) woke = woke | (WAKE === 1'b1);
    pins <= 10'h3FF;
    chk({woke, STOP_MODE}, 32'h2);
    rd_chk(IDX_PIN_FLAG, 32'h01);
    wr(IDX_PIN_FLAG, 32'h0);
    // idle, left by a pending request
    wr(IDX_CTRL, 32'h3);
    wr(IDX_PWR, 32'h01);
    @(negedge MCLK) chk(32'(IDLE_MODE), 32'h1);
    @(posedge MCLK) TMR0_OVF <= 1'b1;
    @(posedge MCLK) TMR0_OVF <= 1'b0;
    repeat (3) @(posedge MCLK);
    @(negedge MCLK) chk(32'(IDLE_MODE), 32'h0);
    rd_chk(IDX_PWR, 32'h0);
    // status and mask drive the one interrupt line
    wr(IDX_STAT, 32'h1F);
    wr(IDX_MASK, 32'h04);
    chk(32'(IRQ), 32'h0);
    @(posedge MCLK) TMR1_OVF <= 1'b1;
    @(posedge MCLK) TMR1_OVF <= 1'b0;
    @(negedge MCLK) chk(32'(IRQ), 32'h1);
    rd_chk(IDX_STAT, 32'h04);
    wr(IDX_MASK, 32'h0);
    @(negedge MCLK) chk(32'(IRQ), 32'h0);
    wr(IDX_MASK, 32'h04);
    @(negedge MCLK) chk(32'(IRQ), 32'h1);
    wr(IDX_STAT, 32'h04);
    @(negedge MCLK) chk(32'(IRQ), 32'h0);
    rd_chk(IDX_STAT, 32'h0);
    give_verdict;
  end
endmodule // ext_int_timer_flag_power_ctrl_tb
`default_nettype wire
